// [aisc_asserts.sv]
`default_nettype none
module aisc_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port and settings
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] int_enable,
   input wire logic write_clear_select,
   // outputs under watch
   input wire logic [7:0] interrupt_flags,
   input wire logic any_flag_pending,
   input wire logic [7:0] feature_control_one,
   input wire logic axis_update_en,
   input wire logic spi_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ========
   // clears with all sources masked, so no set races them
   sequence s_wr_clr;
      reg_wr && reg_addr == 8'h09 && int_enable == 8'h00;
   endsequence
   sequence s_rd_clr;
      reg_rd && !reg_wr && reg_addr == 8'h09 && int_enable == 8'h00 && !write_clear_select;
   endsequence
   AST_RSVD:
      assert property (interrupt_flags[1:0] == 2'h0) else $error("reserved bit set");
   AST_LOWF:
      assert property (feature_control_one[2:0] == 3'h0) else $error("low bits kept");
   AST_EN:
      assert property ((interrupt_flags[7:2] & ~$past(interrupt_flags[7:2])
         & ~$past(int_enable[7:2])) == 6'h00) else $error("masked flag set");
   AST_WRC:
      assert property (s_wr_clr |=> interrupt_flags == 8'h00) else $error("write no clear");
   AST_RDC:
      assert property (s_rd_clr ##0 !spi_active |=> interrupt_flags == 8'h00)
         else $error("read no clear");
   AST_KEEP:
      assert property (reg_rd && !reg_wr && reg_addr == 8'h09 && (spi_active
         || write_clear_select) |=> (interrupt_flags & $past(interrupt_flags))
         == $past(interrupt_flags)) else $error("read cleared");
   AST_PEND:
      assert property ($stable(interrupt_flags) |-> any_flag_pending
         == (interrupt_flags != 8'h00)) else $error("summary wrong");
   AST_AXIS:
      assert property ($stable(feature_control_one) && feature_control_one[7:5] == 3'h0
         |-> !axis_update_en) else $error("axis update");
   AST_NOSPI:
      assert property ($stable(feature_control_one) && feature_control_one[6]
         |-> !spi_active) else $error("spi on");
endmodule // aisc_asserts
bind aisc_int_status aisc_asserts u_chk (.clk, .rstn, .reg_rd, .reg_wr, .reg_addr,
   .int_enable, .write_clear_select, .interrupt_flags, .any_flag_pending,
   .feature_control_one, .axis_update_en, .spi_active);
`default_nettype wire

// [aisc_defines.vh]
`ifndef AISC_DEFINES_VH
`define AISC_DEFINES_VH
// =============================================
// register offsets
`define AISC_ADDR_STATUS1 8'h08
`define AISC_ADDR_FLAGS 8'h09
`define AISC_ADDR_FEAT1 8'h0D
`define AISC_ADDR_FEAT2 8'h0E
`define AISC_ADDR_INTCTL 8'h17
`define AISC_ADDR_THRESH 8'h16
// =============================================
// reset values
`define AISC_FLAGS_RST 8'h00
`define AISC_FEAT1_RST 8'h00
// =============================================
// flag bit positions
`define AISC_BIT_WAKE 2
`define AISC_BIT_ACQ 3
`define AISC_BIT_EMPTY 4
`define AISC_BIT_FULL 5
`define AISC_BIT_LEVEL 6
`define AISC_BIT_COMBINED_WATCH_SAMPLE_MODE 7
// feature control one bit positions
`define AISC_BIT_FREEZE 3
`define AISC_BIT_REARM 4
`define AISC_BIT_SPI3 5
`define AISC_BIT_TWI 6
`define AISC_BIT_SPI 7
// feature two: write-clear select
`define AISC_BIT_WRCLR 4
// =============================================
// operating mode codes
`define AISC_MODE_SNIFF 3'h2
`define AISC_MODE_CONTINUOUS_SAMPLING_MODE 3'h5
`define AISC_MODE_COMBINED_WATCH_SAMPLE_MODE 3'h6
`define AISC_MODE_TRIGGERED_BURST_MODE 3'h7
// full queue depth
`define AISC_QUEUE_DEPTH 6'h20
`endif

// [aisc_host.sv]
`default_nettype none
module aisc_host (
   // clock from the bench
   input wire logic clk,
   // register strobes toward the device
   output var logic reg_rd,
   output var logic reg_wr,
   output var logic [7:0] reg_addr,
   output var logic [7:0] reg_wdata,
   // serial clock, still between frames
   output var logic link_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   // ========
   // idle bus
   initial begin
      {reg_rd, reg_wr, link_clk} = 3'h0;
      {reg_addr, reg_wdata} = 16'h0000;
   end
   // frame of four link clocks, then one access
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      repeat (4) begin
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
      @(posedge clk) #1;
      {reg_rd, reg_wr, reg_addr, reg_wdata} = {!w, w, a, d};
      @(posedge clk) #1;
      // released lines show the inverse, not a stale copy
      {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
      @(posedge clk) #1;
   endtask
endmodule // aisc_host
`default_nettype wire

// [aisc_int_status.v]
// Notes on behaviour
// - flag sets only when its enable is one
// - two-wire default: reading flags clears them
// - SPI or write-clear: any write clears flags
// - wake flag on automatic sniff to wake
// - acquisition flag on each sample, wake/triggered_burst_mode
// - empty flag rearms after leaving empty
// - full flag at 32, rearms after leaving
// - level flag when count reaches threshold
// - sniff-in-wake flag; detector then stalls
// - rearm bit lets clear reset detector
// - freeze bit stops capture on sniff event
// - no axis updates while no interface selected
// - all zero keeps power-up interface type
// - two-wire select disables SPI access
// - SPI select disables two-wire access unless the two-wire bit is also set
// - three-wire bit picks SPI variant
// - pending summary is OR of flags
// - write-clear select stops read clearing
`default_nettype none
module aisc_int_status (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port from the serial front end
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // power-up interface strap: 1 two-wire, 0 spi
   input wire strap_two_wire,
   // settings held elsewhere
   input wire [7:0] int_enable,
   input wire [4:0] level_threshold,
   input wire write_clear_select,
   // core status
   input wire [2:0] op_mode,
   input wire auto_wake_event,
   input wire sample_event,
   input wire [5:0] queue_count,
   input wire sniff_detect,
   // link clock of the serial port, seen as a level
   input wire link_clk,
   // outputs
   output reg [7:0] interrupt_flags,
   output reg any_flag_pending,
   output reg [7:0] feature_control_one,
   output reg axis_update_en,
   output reg capture_en,
   output reg sniff_detector_reset,
   output reg sniff_detector_armed,
   output reg two_wire_active,
   output reg spi_active,
   output reg three_wire_select,
   output reg serial_out_bidir,
   output reg link_clk_rise
);
`include "aisc_defines.vh"

// =============================================
// link clock sampling
reg [2:0] lclk_sync_reg;
reg lclk_state_reg;
// count an edge once the second and third stages agree
always @(posedge clk) begin
   if (!rstn) begin
      lclk_sync_reg <= 3'h0;
      lclk_state_reg <= 1'b0;
      link_clk_rise <= 1'b0;
   end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
      link_clk_rise <= 1'b0;
      if (lclk_sync_reg[1] == lclk_sync_reg[2] && lclk_sync_reg[2] != lclk_state_reg) begin
         lclk_state_reg <= lclk_sync_reg[2];
         link_clk_rise <= lclk_sync_reg[2];
      end
   end
end

// =============================================
// power-up interface strap, caught after reset release
reg strap_taken_reg;
reg strap_two_wire_reg;
always @(posedge clk) begin
   if (!rstn) begin
      strap_taken_reg <= 1'b0;
      strap_two_wire_reg <= 1'b0;
   end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_two_wire_reg <= strap_two_wire;
   end
end

// =============================================
// interface selection
wire sel_twi = feature_control_one[`AISC_BIT_TWI];
wire sel_spi = feature_control_one[`AISC_BIT_SPI];
wire sel_none = !sel_twi && !sel_spi && !feature_control_one[`AISC_BIT_SPI3];
reg twi_mode;
always @* begin
   if (sel_twi)
      twi_mode = 1'b1;
   else if (sel_spi || feature_control_one[`AISC_BIT_SPI3])
      twi_mode = 1'b0;
   else
      twi_mode = strap_two_wire_reg;
end

// =============================================
// register access decode
wire flags_rd = reg_rd && reg_addr == `AISC_ADDR_FLAGS;
wire flags_wr = reg_wr && reg_addr == `AISC_ADDR_FLAGS;
wire feat1_wr = reg_wr && reg_addr == `AISC_ADDR_FEAT1;
wire flag_clear = flags_wr || (flags_rd && twi_mode && !write_clear_select);
// sniff detector reset on rearm clear or leaving combined mode
wire in_combined_watch_sample_mode = op_mode == `AISC_MODE_COMBINED_WATCH_SAMPLE_MODE;
reg in_combined_watch_sample_mode_reg;
wire sniff_reset = (flag_clear && feature_control_one[`AISC_BIT_REARM]) ||
                   (in_combined_watch_sample_mode_reg && !in_combined_watch_sample_mode);

// =============================================
// condition tracking for retrigger
reg [2:0] prev_mode_reg;
reg empty_armed_reg;
reg full_armed_reg;
wire q_empty = queue_count == 6'h00;
wire q_full = queue_count >= `AISC_QUEUE_DEPTH;
always @(posedge clk) begin
   if (!rstn) begin
      prev_mode_reg <= 3'h0;
      in_combined_watch_sample_mode_reg <= 1'b0;
      empty_armed_reg <= 1'b1;
      full_armed_reg <= 1'b1;
   end else begin
      prev_mode_reg <= op_mode;
      in_combined_watch_sample_mode_reg <= in_combined_watch_sample_mode;
      if (!q_empty)
         empty_armed_reg <= 1'b1;
      else if (empty_armed_reg)
         empty_armed_reg <= 1'b0;
      if (!q_full)
         full_armed_reg <= 1'b1;
      else if (full_armed_reg)
         full_armed_reg <= 1'b0;
   end
end

// =============================================
// flag set terms
reg [7:0] set_vec;
always @* begin
   set_vec = 8'h00;
   set_vec[`AISC_BIT_WAKE] = auto_wake_event && prev_mode_reg == `AISC_MODE_SNIFF &&
                             op_mode == `AISC_MODE_CONTINUOUS_SAMPLING_MODE;
   set_vec[`AISC_BIT_ACQ] = sample_event &&
      (op_mode == `AISC_MODE_CONTINUOUS_SAMPLING_MODE || op_mode == `AISC_MODE_TRIGGERED_BURST_MODE);
   set_vec[`AISC_BIT_EMPTY] = q_empty && empty_armed_reg;
   set_vec[`AISC_BIT_FULL] = q_full && full_armed_reg;
   set_vec[`AISC_BIT_LEVEL] = {1'b0, queue_count} >= {2'h0, level_threshold};
   // sniff only in combined mode while armed
   set_vec[`AISC_BIT_COMBINED_WATCH_SAMPLE_MODE] = sniff_detect && in_combined_watch_sample_mode && sniff_detector_armed;
   set_vec = set_vec & int_enable & 8'hFC;
end

// =============================================
// flags, feature register and derived outputs
wire [7:0] flags_next = (flag_clear ? 8'h00 : interrupt_flags) | set_vec;
always @(posedge clk) begin
   if (!rstn) begin
      interrupt_flags <= `AISC_FLAGS_RST;
      any_flag_pending <= 1'b0;
      feature_control_one <= `AISC_FEAT1_RST;
      sniff_detector_armed <= 1'b1;
      sniff_detector_reset <= 1'b0;
      capture_en <= 1'b1;
   end else begin
      // clear all at once, set wins
      interrupt_flags <= flags_next;
      any_flag_pending <= |flags_next;
      // low bits forced zero, host owes zeros
      if (feat1_wr)
         feature_control_one <= {reg_wdata[7:3], 3'h0};
      sniff_detector_reset <= sniff_reset;
      // detector stalls after event until reset
      if (set_vec[`AISC_BIT_COMBINED_WATCH_SAMPLE_MODE])
         sniff_detector_armed <= 1'b0;
      else if (sniff_reset)
         sniff_detector_armed <= 1'b1;
      if (set_vec[`AISC_BIT_COMBINED_WATCH_SAMPLE_MODE] && feature_control_one[`AISC_BIT_FREEZE])
         capture_en <= 1'b0;
      else if (!feature_control_one[`AISC_BIT_FREEZE] || flag_clear)
         capture_en <= 1'b1;
   end
end

// =============================================
// interface outputs
always @(posedge clk) begin
   if (!rstn) begin
      axis_update_en <= 1'b0;
      two_wire_active <= 1'b0;
      spi_active <= 1'b0;
      three_wire_select <= 1'b0;
      serial_out_bidir <= 1'b0;
   end else begin
      axis_update_en <= !sel_none;
      two_wire_active <= twi_mode;
      spi_active <= !twi_mode;
      three_wire_select <= feature_control_one[`AISC_BIT_SPI3];
      serial_out_bidir <= !twi_mode && feature_control_one[`AISC_BIT_SPI3];
   end
end

// =============================================
// read data, registered one cycle after the read strobe
always @(posedge clk) begin
   if (!rstn)
      reg_rdata <= 8'h00;
   else if (reg_rd) begin
      case (reg_addr)
         `AISC_ADDR_FLAGS: reg_rdata <= interrupt_flags;
         `AISC_ADDR_FEAT1: reg_rdata <= feature_control_one;
         `AISC_ADDR_STATUS1: reg_rdata <= {any_flag_pending, 7'h00};
         default: reg_rdata <= 8'h00;
      endcase
   end
end
endmodule // aisc_int_status
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ========
   // stimulus and observed signals
   logic clk, rstn, wcs, aw, se, sd, pend, ax, cap, arm, tw, sp, s3, bi, lr;
   logic [7:0] ien, rdat, fl, fc;
   logic [2:0] md;
   logic [5:0] qc;
   // detector reset pulse and the level threshold, driven so is not a tie-off
   logic sr;
   logic [4:0] thr;
   int nsr = 0;
   wire logic reg_rd, reg_wr, link_clk;
   wire logic [7:0] reg_addr, reg_wdata;
   int n_errors = 0, checks = 0, nr = 0;
   aisc_int_status dut (.clk, .rstn, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
      .reg_rdata(rdat), .strap_two_wire(1'b1), .int_enable(ien), .level_threshold(thr),
      .write_clear_select(wcs), .op_mode(md), .auto_wake_event(aw), .sample_event(se),
      .queue_count(qc), .sniff_detect(sd), .link_clk, .interrupt_flags(fl),
      .any_flag_pending(pend), .feature_control_one(fc), .axis_update_en(ax),
      .capture_en(cap), .sniff_detector_reset(sr), .sniff_detector_armed(arm),
      .two_wire_active(tw), .spi_active(sp), .three_wire_select(s3),
      .serial_out_bidir(bi), .link_clk_rise(lr));
   aisc_host host (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .link_clk);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // count filtered link clock rises
   always @(posedge clk) begin
      if (lr === 1'b1) nr <= nr + 1;
   end
   // count detector reset pulses, one per clear with rearm or exit from combined mode
   always @(posedge clk) begin
      if (sr === 1'b1) nsr <= nsr + 1;
   end
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic final_report();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ========
   // scenarios
   task automatic t_feat();
      ck({fc[7:1], ax}, 8'h00);
      host.acc(1'b1, 8'h0D, 8'h5F);
      ck(fc, 8'h58);
      ck({5'h0, tw, sp, ax}, 8'h05);
      ck(8'(nr), 8'h04);
   endtask
   task automatic t_empty();
      {ien, qc} = {8'hFC, 6'h00};
      host.acc(1'b0, 8'h09, 8'h00);
      ck(rdat, 8'h10);
      ck(fl, 8'h00);
      qc = 6'h01;
      cyc(2);
      qc = 6'h00;
      cyc(2);
      ck(fl, 8'h10);
      ck({7'h0, pend}, 8'h01);
      ien = 8'h00;
      host.acc(1'b0, 8'h09, 8'h00);
      qc = 6'h01;
      cyc(2);
      qc = 6'h00;
      cyc(2);
      ck(fl, 8'h00);
      qc = 6'h01;
   endtask
   task automatic t_wrclr();
      {ien, wcs, qc} = {8'hFC, 1'b1, 6'h20};
      host.acc(1'b0, 8'h09, 8'h00);
      ck(rdat, 8'h60);
      ck(fl, 8'h60);
      host.acc(1'b1, 8'h09, 8'hA5);
      ck(fl, 8'h40);
      ien = 8'h00;
      host.acc(1'b1, 8'h09, 8'h00);
      ck(fl, 8'h00);
      {wcs, qc} = {1'b0, 6'h05};
   endtask
   task automatic t_modes();
      {ien, md} = {8'hFC, 3'h2};
      cyc(2);
      {md, aw} = {3'h5, 1'b1};
      cyc(1);
      {aw, se} = 2'b01;
      cyc(1);
      {se, sd, md} = {2'b01, 3'h6};
      ck(fl, 8'h0C);
      cyc(1);
      sd = 1'b0;
      cyc(2);
      ck(fl, 8'h8C);
      ck({6'h0, cap, arm}, 8'h00);
      ien = 8'h00;
      host.acc(1'b0, 8'h09, 8'h00);
      ck({6'h0, cap, arm}, 8'h03);
      md = 3'h1;
      cyc(2);
      ck(8'(nsr), 8'h06);
   endtask
   task automatic t_spi();
      host.acc(1'b1, 8'h0D, 8'h80);
      ck({3'h0, tw, sp, s3, bi, ax}, 8'h09);
      host.acc(1'b1, 8'h0D, 8'hA0);
      ck({3'h0, tw, sp, s3, bi, ax}, 8'h0F);
      host.acc(1'b1, 8'h0D, 8'h00);
      ck({3'h0, tw, sp, s3, bi, ax}, 8'h10);
   endtask
   initial begin
      {rstn, wcs, aw, se, sd} = 5'h00;
      {ien, md, qc} = {8'h00, 3'h1, 6'h01};
      thr = 5'h1F;
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      t_feat();
      t_empty();
      t_wrclr();
      t_modes();
      t_spi();
      final_report();
   end
   // cut a hang short
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule // tb_top
`default_nettype wire
